// ### common/psr_defines.vh
// constants for the special-purpose register set: register numbers,
// field positions and timing counts.
// assumes it is included by its bare name from the design files.
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH

// =====================================================================
// register numbers
`define PSR_N_FAULT_CAUSE 10'h012
`define PSR_N_FAULT_ADDR 10'h013
`define PSR_N_DOWN_TIMER 10'h016
`define PSR_N_SAVE_PC 10'h01A
`define PSR_N_SAVE_STATUS 10'h01B
`define PSR_N_TIME_LO_RD 10'h10C
`define PSR_N_TIME_HI_RD 10'h10D
`define PSR_N_TIME_LO_WR 10'h11C
`define PSR_N_TIME_HI_WR 10'h11D
`define PSR_N_VERSION 10'h11F
`define PSR_N_THERM_OFFSET 10'h398
`define PSR_N_USER_EVT1 10'h3A9
`define PSR_N_USER_EVT2 10'h3AA
`define PSR_N_USER_SIA 10'h3AB
`define PSR_N_USER_EVT3 10'h3AD
`define PSR_N_USER_EVT4 10'h3AE
`define PSR_N_USER_DATA_STUB 10'h3AF
`define PSR_N_EVT1 10'h3B9
`define PSR_N_EVT2 10'h3BA
`define PSR_N_SIA 10'h3BB
`define PSR_N_EVT3 10'h3BD
`define PSR_N_EVT4 10'h3BE
`define PSR_N_DATA_STUB 10'h3BF
`define PSR_N_PLL_MIRROR 10'h3F1
`define PSR_N_THERM_ONE 10'h3FC
`define PSR_N_THERM_TWO 10'h3FD
`define PSR_N_THERM_CTRL 10'h3FE

// =====================================================================
// access classes returned by the number decoder
`define PSR_C_NONE 3'h0
`define PSR_C_SUPER 3'h1
`define PSR_C_USER_RD 3'h2
`define PSR_C_USER_ALIAS 3'h3
`define PSR_C_READ_ONLY 3'h4
`define PSR_C_WRITE_STUB 3'h5

// =====================================================================
// field positions (bit 0 is the least significant bit)
`define PSR_SEG_DIRECT_BIT 31
`define PSR_BAT_GUARD_BIT 3
`define PSR_BAT_VS_BIT 1
`define PSR_BAT_VP_BIT 0
`define PSR_MC_CACHE_PARITY_BIT 27
`define PSR_MC_L2_DOUBLE_BIT 20
`define PSR_MC_PIN_BIT 19
`define PSR_MC_TRANSFER_ERR_BIT 18
`define PSR_MC_DATA_PARITY_BIT 17
`define PSR_MC_ADDR_PARITY_BIT 16
`define PSR_TH_RESULT_BIT 31
`define PSR_TH_VALID_RES_BIT 30
`define PSR_TH_LEVEL_HI 29
`define PSR_TH_LEVEL_LO 23
`define PSR_TH_DIR_BIT 2
`define PSR_TH_INT_EN_BIT 1
`define PSR_TH_ENABLE_BIT 0
`define PSR_TC_ENABLE_BIT 0

// =====================================================================
// reset values and timing
`define PSR_RESET_WORD 32'h00000000
`define PSR_TICK_DIVIDE 2'h3

`endif

// ### verilog/psr_tick_div.v
// quarter-rate divider for the timer tick.
// assumes BUS_TICK-style input is a one-cycle pulse per bus clock period.
`timescale 1ns/1ps
`include "psr_defines.vh"

module psr_tick_div (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // ticks
    input wire bus_tick,
    output reg quarter_tick
);
    reg [1:0] count;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 2'h0;
            quarter_tick <= 1'b0;
        end else begin
            quarter_tick <= 1'b0;
            if (bus_tick) begin
                if (count == `PSR_TICK_DIVIDE) begin
                    count <= 2'h0;
                    quarter_tick <= 1'b1;
                end else begin
                    count <= count + 2'h1;
                end
            end
        end
    end
endmodule

// ### verilog/psr_spr_file.v
// special-purpose register set of the core, reached by move-to and
// move-from register-number requests from the execute stage.
// assumes requests, exception events and pins are synchronous to CLK.
//
// What this block does
// (RQ1) read-only version register gives model number and revision level
// (RQ2) eight instruction and eight data block translation upper/lower pairs
// (RQ3) software keeps translations valid while halves are written apart
// (RQ4) guard bit kept in instruction entries; guarded fetch raises storage fault
// (RQ5) sixteen 32-bit segment descriptors, meaning set by bit 0
// (RQ6) segment writes mirrored into shadow copies for instruction translation
// (RQ7) data storage or alignment fault loads the fault effective address
// (RQ8) fault cause register records why the data fault happened
// (RQ9) exception saves resume address; return continues from it
// (RQ10) exception saves machine status; return restores it
// (RQ11) machine check sets bits 4, 11, 12 for parity, ECC, pin
// (RQ12) machine check sets bits 13, 14, 15 for bus errors
// (RQ13) 64-bit time count readable by all, written by supervisor only
// (RQ14) 32-bit down counter raises exception when delay elapses
// (RQ15) time count and down counter step at quarter bus clock rate
// (RQ16) implementation-specific registers are supervisor-only
// (RQ17) pll mirror shows five config pins plus selection and range
// (RQ18) four event counters, each with user read-only alias
// (RQ19) sampled instruction address taken at monitor signal, user alias
// (RQ20) writes to both sampled-data stub numbers accepted, no exception
// (RQ21) two thermal thresholds, single-threshold mode uses only one
// (RQ22) thermal offset register is read-only, added to temperature
// (RQ23) full number decode; undefined number raises illegal-instruction fault
// (RQ24) access is by move-to and move-from with register number
// (RQ25) user write to supervisor register faults and changes nothing
`timescale 1ns/1ps
`include "psr_defines.vh"

module psr_spr_file #(
    parameter [15:0] MODEL_NUMBER = 16'hA5C3, // arbitrary value
    parameter [15:0] REVISION_LEVEL = 16'h0001, // arbitrary value
    parameter [7:0] THERMAL_OFFSET = 8'h00
) (
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // move-to / move-from request
    input wire SPR_VALID,
    input wire SPR_WRITE,
    input wire [9:0] SPR_NUM,
    input wire [31:0] SPR_WDATA,
    input wire SUPERVISOR,
    output reg SPR_ACK,
    output reg [31:0] SPR_RDATA,
    output reg PRIV_FAULT,
    output reg ILLEGAL_FAULT,
    // segment descriptor access
    input wire SEG_WE,
    input wire [3:0] SEG_IDX,
    input wire [31:0] SEG_WDATA,
    output reg [31:0] SEG_RDATA,
    // instruction-side shadow segment and fetch check
    input wire [3:0] FETCH_SEG_IDX,
    output reg [31:0] FETCH_SEG_DATA,
    input wire FETCH_VALID,
    input wire [31:0] FETCH_EA,
    output reg FETCH_GUARD_FAULT,
    // exception capture and return
    input wire EXC_TAKE,
    input wire [31:0] EXC_PC,
    input wire [31:0] EXC_MSR,
    input wire EXC_DATA_FAULT,
    input wire [31:0] EXC_EA,
    input wire [31:0] EXC_CAUSE,
    input wire EXC_MCHK,
    input wire [5:0] MCHK_CAUSE,
    output reg [31:0] RESUME_PC,
    output reg [31:0] RESUME_MSR,
    // timers
    input wire BUS_TICK,
    output reg DEC_EXC,
    // pll configuration pins
    input wire [4:0] PLL_CFG,
    input wire PLL_SEL,
    input wire [1:0] PLL_RANGE,
    // performance monitor
    input wire [3:0] EVENT_HIT,
    input wire PERF_SIGNAL,
    input wire [31:0] CURRENT_PC,
    // thermal sensor
    input wire [6:0] JUNCTION_TEMP,
    output reg THERM_EXC
);
    // =================================================================
    // reset release
    reg rst_meta;
    reg rst_n;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // =================================================================
    // number decoder
    function [2:0] spr_class;
        input [9:0] n;
        begin
            spr_class = `PSR_C_NONE;
            if (n[9:6] == 4'h8 && n[4]) begin
                spr_class = `PSR_C_SUPER;
            end
            case (n)
                `PSR_N_FAULT_CAUSE, `PSR_N_FAULT_ADDR, `PSR_N_DOWN_TIMER,
                `PSR_N_SAVE_PC, `PSR_N_SAVE_STATUS, `PSR_N_TIME_LO_WR,
                `PSR_N_TIME_HI_WR, `PSR_N_EVT1, `PSR_N_EVT2, `PSR_N_EVT3,
                `PSR_N_EVT4, `PSR_N_SIA, `PSR_N_THERM_ONE,
                `PSR_N_THERM_TWO, `PSR_N_THERM_CTRL:
                    spr_class = `PSR_C_SUPER;
                `PSR_N_TIME_LO_RD, `PSR_N_TIME_HI_RD:
                    spr_class = `PSR_C_USER_RD;
                `PSR_N_USER_EVT1, `PSR_N_USER_EVT2, `PSR_N_USER_EVT3,
                `PSR_N_USER_EVT4, `PSR_N_USER_SIA:
                    spr_class = `PSR_C_USER_ALIAS;
                `PSR_N_VERSION, `PSR_N_THERM_OFFSET, `PSR_N_PLL_MIRROR:
                    spr_class = `PSR_C_READ_ONLY;
                `PSR_N_DATA_STUB, `PSR_N_USER_DATA_STUB:
                    spr_class = `PSR_C_WRITE_STUB;
                default: spr_class = spr_class;
            endcase
        end
    endfunction

    // event counter index for either the supervisor or the user number
    function [1:0] evt_index;
        input [9:0] n;
        begin
            case (n[3:0])
                4'h9: evt_index = 2'h0;
                4'hA: evt_index = 2'h1;
                4'hD: evt_index = 2'h2;
                default: evt_index = 2'h3;
            endcase
        end
    endfunction

    // =================================================================
    // storage
    reg [31:0] bat_upper [0:15];
    reg [31:0] bat_lower [0:15];
    reg [31:0] seg_arch [0:15];
    reg [31:0] seg_shadow [0:15];
    reg [31:0] fault_addr;
    reg [31:0] fault_cause;
    reg [31:0] save_restore_pc;
    reg [31:0] save_restore_status;
    reg [63:0] time_count;
    reg [31:0] down_counter_timer;
    reg [31:0] event_counters [0:3];
    reg [31:0] sampled_instr_address;
    reg [31:0] thermal_threshold_one;
    reg [31:0] thermal_threshold_two;
    reg [31:0] thermal_unit_control;
    reg [31:0] pll_config_mirror;

    wire quarter_tick;
    wire [2:0] req_class = spr_class(SPR_NUM);
    wire [3:0] bat_idx = {SPR_NUM[3], SPR_NUM[5], SPR_NUM[2:1]};
    wire [1:0] evt_idx = evt_index(SPR_NUM);
    wire is_user_level = (req_class == `PSR_C_USER_RD) ||
        (req_class == `PSR_C_USER_ALIAS) || (req_class == `PSR_C_WRITE_STUB); // RQ20
    wire bad_direction = SPR_WRITE ?
        (req_class == `PSR_C_USER_ALIAS || req_class == `PSR_C_READ_ONLY ||
         req_class == `PSR_C_USER_RD) :
        (req_class == `PSR_C_WRITE_STUB);
    wire req_illegal = (req_class == `PSR_C_NONE) || bad_direction;
    wire req_priv = !req_illegal && !SUPERVISOR && !is_user_level;
    wire do_write = SPR_VALID && SPR_WRITE && !req_illegal && !req_priv;

    psr_tick_div u_tick_div (
        .clk(CLK),
        .rst_n(rst_n),
        .bus_tick(BUS_TICK),
        .quarter_tick(quarter_tick)
    );

    // =================================================================
    // request answer, registered one cycle after the request
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h00000000;
        if (req_class == `PSR_C_SUPER && SPR_NUM[9:6] == 4'h8) begin
            next_rdata = SPR_NUM[0] ? bat_lower[bat_idx] : bat_upper[bat_idx];
        end
        case (SPR_NUM)
            `PSR_N_VERSION: next_rdata = {MODEL_NUMBER, REVISION_LEVEL}; // RQ1
            `PSR_N_FAULT_ADDR: next_rdata = fault_addr;
            `PSR_N_FAULT_CAUSE: next_rdata = fault_cause;
            `PSR_N_SAVE_PC: next_rdata = save_restore_pc;
            `PSR_N_SAVE_STATUS: next_rdata = save_restore_status;
            `PSR_N_TIME_LO_RD: next_rdata = time_count[31:0]; // RQ13
            `PSR_N_TIME_HI_RD: next_rdata = time_count[63:32]; // RQ13
            `PSR_N_DOWN_TIMER: next_rdata = down_counter_timer;
            `PSR_N_PLL_MIRROR: next_rdata = pll_config_mirror;
            `PSR_N_EVT1, `PSR_N_EVT2, `PSR_N_EVT3, `PSR_N_EVT4,
            `PSR_N_USER_EVT1, `PSR_N_USER_EVT2, `PSR_N_USER_EVT3,
            `PSR_N_USER_EVT4:
                next_rdata = event_counters[evt_idx]; // RQ18
            `PSR_N_SIA, `PSR_N_USER_SIA: next_rdata = sampled_instr_address; // RQ19
            `PSR_N_THERM_ONE: next_rdata = thermal_threshold_one;
            `PSR_N_THERM_TWO: next_rdata = thermal_threshold_two;
            `PSR_N_THERM_CTRL: next_rdata = thermal_unit_control;
            `PSR_N_THERM_OFFSET: next_rdata = {24'h000000, THERMAL_OFFSET}; // RQ22
            default: next_rdata = next_rdata;
        endcase
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SPR_ACK <= 1'b0;
            SPR_RDATA <= `PSR_RESET_WORD;
            PRIV_FAULT <= 1'b0;
            ILLEGAL_FAULT <= 1'b0;
        end else begin
            SPR_ACK <= SPR_VALID || SEG_WE; // RQ24
            SPR_RDATA <= (SPR_VALID && !SPR_WRITE && !req_illegal && !req_priv) ?
                next_rdata : 32'h00000000;
            ILLEGAL_FAULT <= SPR_VALID && req_illegal; // RQ23
            PRIV_FAULT <= (SPR_VALID && req_priv) || (SEG_WE && !SUPERVISOR); // RQ16 RQ25
        end
    end

    // =================================================================
    // translation entries and segment descriptors
    integer i;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 16; i = i + 1) begin
                bat_upper[i] <= `PSR_RESET_WORD;
                bat_lower[i] <= `PSR_RESET_WORD;
                seg_arch[i] <= `PSR_RESET_WORD;
                seg_shadow[i] <= `PSR_RESET_WORD;
            end
        end else begin
            // each half is its own write; no pairing is enforced here
            if (do_write && req_class == `PSR_C_SUPER && SPR_NUM[9:6] == 4'h8) begin
                if (SPR_NUM[0]) begin
                    bat_lower[bat_idx] <= SPR_WDATA; // RQ2 RQ3
                end else begin
                    bat_upper[bat_idx] <= SPR_WDATA; // RQ2
                end
            end
            if (SEG_WE && SUPERVISOR) begin
                seg_arch[SEG_IDX] <= SEG_WDATA; // RQ5
                seg_shadow[SEG_IDX] <= SEG_WDATA; // RQ6
            end
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SEG_RDATA <= `PSR_RESET_WORD;
            FETCH_SEG_DATA <= `PSR_RESET_WORD;
        end else begin
            SEG_RDATA <= seg_arch[SEG_IDX];
            FETCH_SEG_DATA <= seg_shadow[FETCH_SEG_IDX]; // RQ6
        end
    end

    // guarded-block check across the eight instruction entries
    wire [7:0] guard_hit;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_instr_block_translation
            wire [14:0] len_mask = {4'h0, bat_upper[g][12:2]};
            wire valid = SUPERVISOR ? bat_upper[g][`PSR_BAT_VS_BIT] :
                bat_upper[g][`PSR_BAT_VP_BIT];
            wire match = ((FETCH_EA[31:17] & ~len_mask) ==
                (bat_upper[g][31:17] & ~len_mask));
            assign guard_hit[g] = valid && match &&
                bat_lower[g][`PSR_BAT_GUARD_BIT];
        end
    endgenerate

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            FETCH_GUARD_FAULT <= 1'b0;
        end else begin
            FETCH_GUARD_FAULT <= FETCH_VALID && (|guard_hit); // RQ4
        end
    end

    // =================================================================
    // exception save/restore; hardware capture wins over a same-cycle write
    wire [31:0] mchk_bits = {
        4'h0,
        MCHK_CAUSE[5],
        6'h00,
        MCHK_CAUSE[4],
        MCHK_CAUSE[3],
        MCHK_CAUSE[2],
        MCHK_CAUSE[1],
        MCHK_CAUSE[0],
        16'h0000
    };

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fault_addr <= `PSR_RESET_WORD;
            fault_cause <= `PSR_RESET_WORD;
            save_restore_pc <= `PSR_RESET_WORD;
            save_restore_status <= `PSR_RESET_WORD;
        end else if (EXC_TAKE) begin
            save_restore_pc <= EXC_PC; // RQ9
            save_restore_status <= EXC_MCHK ? (EXC_MSR | mchk_bits) : EXC_MSR; // RQ10 RQ11 RQ12
            if (EXC_DATA_FAULT) begin
                fault_addr <= EXC_EA; // RQ7
                fault_cause <= EXC_CAUSE; // RQ8
            end
        end else if (do_write) begin
            case (SPR_NUM)
                `PSR_N_FAULT_ADDR: fault_addr <= SPR_WDATA;
                `PSR_N_FAULT_CAUSE: fault_cause <= SPR_WDATA;
                `PSR_N_SAVE_PC: save_restore_pc <= SPR_WDATA;
                `PSR_N_SAVE_STATUS: save_restore_status <= SPR_WDATA;
                default: fault_addr <= fault_addr;
            endcase
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RESUME_PC <= `PSR_RESET_WORD;
            RESUME_MSR <= `PSR_RESET_WORD;
        end else begin
            RESUME_PC <= save_restore_pc; // RQ9
            RESUME_MSR <= save_restore_status; // RQ10
        end
    end

    // =================================================================
    // time count and down counter; a software write beats the tick
    wire [31:0] dec_next = down_counter_timer - 32'h00000001;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            time_count <= 64'h0000000000000000;
            down_counter_timer <= `PSR_RESET_WORD;
            DEC_EXC <= 1'b0;
        end else begin
            DEC_EXC <= 1'b0;
            if (do_write && SPR_NUM == `PSR_N_TIME_LO_WR) begin
                time_count[31:0] <= SPR_WDATA; // RQ13
            end else if (do_write && SPR_NUM == `PSR_N_TIME_HI_WR) begin
                time_count[63:32] <= SPR_WDATA; // RQ13
            end else if (quarter_tick) begin
                time_count <= time_count + 64'h0000000000000001; // RQ15
            end
            if (do_write && SPR_NUM == `PSR_N_DOWN_TIMER) begin
                down_counter_timer <= SPR_WDATA;
            end else if (quarter_tick) begin
                down_counter_timer <= dec_next; // RQ15
                // the delay has run out when the count wraps below zero
                DEC_EXC <= !down_counter_timer[31] && dec_next[31]; // RQ14
            end
        end
    end

    // =================================================================
    // pll mirror, event counters, sampled address
    integer j;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pll_config_mirror <= `PSR_RESET_WORD;
            sampled_instr_address <= `PSR_RESET_WORD;
            for (j = 0; j < 4; j = j + 1) begin
                event_counters[j] <= `PSR_RESET_WORD;
            end
        end else begin
            pll_config_mirror <= {PLL_CFG, PLL_SEL, PLL_RANGE, 24'h000000}; // RQ17
            for (j = 0; j < 4; j = j + 1) begin
                if (do_write && req_class == `PSR_C_SUPER &&
                        SPR_NUM[9:4] == 6'h3B && evt_idx == j[1:0] &&
                        SPR_NUM != `PSR_N_SIA) begin
                    event_counters[j] <= SPR_WDATA;
                end else if (EVENT_HIT[j]) begin
                    event_counters[j] <= event_counters[j] + 32'h00000001; // RQ18
                end
            end
            if (PERF_SIGNAL) begin
                sampled_instr_address <= CURRENT_PC; // RQ19
            end else if (do_write && SPR_NUM == `PSR_N_SIA) begin
                sampled_instr_address <= SPR_WDATA;
            end
            // stub numbers are taken by do_write and simply dropped
        end
    end

    // =================================================================
    // thermal comparison; a threshold with its enable clear is ignored,
    // which gives single-threshold operation
    wire [7:0] temp_adj = {1'b0, JUNCTION_TEMP} + THERMAL_OFFSET; // RQ22
    wire therm_on = thermal_unit_control[`PSR_TC_ENABLE_BIT];

    function th_result;
        input [31:0] th;
        input [7:0] t;
        begin
            if (th[`PSR_TH_DIR_BIT]) begin
                th_result = t < {1'b0, th[`PSR_TH_LEVEL_HI:`PSR_TH_LEVEL_LO]};
            end else begin
                th_result = t > {1'b0, th[`PSR_TH_LEVEL_HI:`PSR_TH_LEVEL_LO]};
            end
        end
    endfunction

    wire one_on = therm_on && thermal_threshold_one[`PSR_TH_ENABLE_BIT];
    wire two_on = therm_on && thermal_threshold_two[`PSR_TH_ENABLE_BIT];
    wire one_res = th_result(thermal_threshold_one, temp_adj);
    wire two_res = th_result(thermal_threshold_two, temp_adj);

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            thermal_threshold_one <= `PSR_RESET_WORD;
            thermal_threshold_two <= `PSR_RESET_WORD;
            thermal_unit_control <= `PSR_RESET_WORD;
            THERM_EXC <= 1'b0;
        end else begin
            if (do_write && SPR_NUM == `PSR_N_THERM_ONE) begin
                thermal_threshold_one <= {2'h0, SPR_WDATA[29:0]};
            end else begin
                thermal_threshold_one[`PSR_TH_RESULT_BIT] <= one_on && one_res; // RQ21
                thermal_threshold_one[`PSR_TH_VALID_RES_BIT] <= one_on;
            end
            if (do_write && SPR_NUM == `PSR_N_THERM_TWO) begin
                thermal_threshold_two <= {2'h0, SPR_WDATA[29:0]};
            end else begin
                thermal_threshold_two[`PSR_TH_RESULT_BIT] <= two_on && two_res; // RQ21
                thermal_threshold_two[`PSR_TH_VALID_RES_BIT] <= two_on;
            end
            if (do_write && SPR_NUM == `PSR_N_THERM_CTRL) begin
                thermal_unit_control <= SPR_WDATA;
            end
            THERM_EXC <= (one_on && one_res &&
                thermal_threshold_one[`PSR_TH_INT_EN_BIT]) ||
                (two_on && two_res && thermal_threshold_two[`PSR_TH_INT_EN_BIT]); // RQ21
        end
    end
endmodule

// ### bench/psr_spr_file_sva.sv
// checker for the register set: answer timing, refusals and status save.
// assumes it is bound to psr_spr_file and sees only its ports.
`timescale 1ns/1ps
module psr_spr_chk (
    // ==========================================================
    // clock, reset and requests
    input wire CLK, input wire RSTN, input wire SPR_VALID, input wire SPR_WRITE,
    input wire [9:0] SPR_NUM, input wire SUPERVISOR, input wire SEG_WE,
    // answers and exceptions
    input wire SPR_ACK, input wire PRIV_FAULT, input wire ILLEGAL_FAULT, input wire EXC_TAKE,
    input wire EXC_MCHK, input wire [5:0] MCHK_CAUSE, input wire [31:0] EXC_MSR,
    input wire [31:0] RESUME_MSR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire rd = SPR_VALID && !SPR_WRITE;
    wire wr = SPR_VALID && SPR_WRITE;
    // causes sit at bits 4 and 11-15 counted from the msb
    wire [31:0] mc_bits = {4'h0, MCHK_CAUSE[5], 6'h0, MCHK_CAUSE[4:0], 16'h0};
    a_ack_one_cycle: assert property (SPR_VALID |=> SPR_ACK)
        else $error("no answer one cycle after request");
    a_ack_has_cause: assert property (SPR_ACK |-> $past(SPR_VALID) || $past(SEG_WE))
        else $error("answer without request");
    a_undef_number: assert property (rd && SPR_NUM == 10'h000 |=> ILLEGAL_FAULT)
        else $error("undefined number not refused");
    a_version_write: assert property (wr && SPR_NUM == 10'h11F |=> ILLEGAL_FAULT)
        else $error("version write not refused");
    a_user_write: assert property (wr && !SUPERVISOR && SPR_NUM == 10'h016 |=> PRIV_FAULT)
        else $error("user write not refused");
    a_stub_write: assert property (wr && SPR_NUM[9:5] == 5'h1D && SPR_NUM[3:0] == 4'hF
        |=> !PRIV_FAULT && !ILLEGAL_FAULT) else $error("stub write faulted");
    a_time_read: assert property (rd && SPR_NUM[9:1] == 9'h086 |=> !PRIV_FAULT)
        else $error("time count read refused");
    a_mchk_status: assert property (EXC_TAKE && EXC_MCHK
        |=> ##1 RESUME_MSR == ($past(EXC_MSR, 2) | $past(mc_bits, 2)))
        else $error("machine check status wrong");
    c_mchk: cover property (EXC_TAKE && EXC_MCHK);
    c_priv: cover property (PRIV_FAULT);
    c_illegal: cover property (ILLEGAL_FAULT);
endmodule
bind psr_spr_file psr_spr_chk chk_u (.*);

// ### bench/psr_spr_file_tb_top.sv
// bench for the register set: move-to/move-from calls with expected values.
// assumes every request is answered one cycle after it is taken.
`timescale 1ns/1ps
module psr_spr_file_tb_top;
    // ==========================================================
    // signals
    logic CLK = 0, RSTN = 0, SPR_VALID = 0, SPR_WRITE = 0, SUPERVISOR = 0, SEG_WE = 0;
    logic FETCH_VALID = 0, EXC_TAKE = 0, EXC_DATA_FAULT = 0, EXC_MCHK = 0, BUS_TICK = 0;
    logic PLL_SEL = 1, PERF_SIGNAL = 0;
    logic [9:0] SPR_NUM = 0;
    logic [3:0] SEG_IDX = 0, FETCH_SEG_IDX = 0, EVENT_HIT = 0;
    logic [31:0] SPR_WDATA = 0, SEG_WDATA = 0, FETCH_EA = 0, EXC_PC = 0, EXC_MSR = 0;
    logic [31:0] EXC_EA = 0, EXC_CAUSE = 0, CURRENT_PC = 0;
    logic [5:0] MCHK_CAUSE = 0;
    logic [4:0] PLL_CFG = 5'h15;
    logic [1:0] PLL_RANGE = 2'h2;
    logic [6:0] JUNCTION_TEMP = 7'h20;
    wire SPR_ACK, PRIV_FAULT, ILLEGAL_FAULT, FETCH_GUARD_FAULT, DEC_EXC, THERM_EXC;
    wire [31:0] SPR_RDATA, SEG_RDATA, FETCH_SEG_DATA, RESUME_PC, RESUME_MSR;
    int fail_count = 0, n_checks = 0, dec_hits = 0;
    localparam [15:0] MODEL = 16'h3C5A; // arbitrary value
    localparam [15:0] REV = 16'h0002; // arbitrary value
    psr_spr_file #(.MODEL_NUMBER(MODEL), .REVISION_LEVEL(REV)) dut_u (.*);
    initial forever #2 CLK = ~CLK;
    always @(posedge CLK) if (DEC_EXC === 1'b1) dec_hits <= dec_hits + 1;
    task chk(input logic [31:0] a, input logic [31:0] e);
        n_checks++;
        if (a !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    // f is {privileged, illegal}; a read also compares d with the read data
    task spr(input logic w, input logic [9:0] n, input logic [31:0] d, input logic s,
             input logic [1:0] f);
        SPR_VALID = 1; SPR_WRITE = w; SPR_NUM = n; SPR_WDATA = d; SUPERVISOR = s;
        @(posedge CLK); #1;
        chk({SPR_ACK, PRIV_FAULT, ILLEGAL_FAULT}, {1'b1, f});
        if (!w) chk(SPR_RDATA, d);
        SPR_VALID = 0;
        @(posedge CLK); #1;
    endtask
    task pulse_edge;
        @(posedge CLK); #1;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLK);
        #1 RSTN = 1;
        repeat (3) pulse_edge;
        spr(0, 10'h11F, {MODEL, REV}, 1, 0);
        spr(1, 10'h11F, 0, 1, 1);
        spr(0, 10'h000, 0, 1, 1);
        spr(1, 10'h016, 32'h1, 1, 0);
        spr(1, 10'h016, 32'h55, 0, 2);
        spr(1, 10'h11C, 32'h10, 1, 0);
        spr(1, 10'h11C, 32'h77, 0, 2);
        // eight bus ticks make two timer steps
        repeat (8) begin
            BUS_TICK = 1;
            pulse_edge;
            BUS_TICK = 0;
            pulse_edge;
        end
        spr(0, 10'h10C, 32'h12, 0, 0);
        spr(0, 10'h016, 32'hFFFFFFFF, 1, 0);
        chk(dec_hits, 1);
        spr(1, 10'h3BF, 32'h1234, 0, 0);
        spr(1, 10'h3AF, 32'h1234, 1, 0);
        spr(0, 10'h3BF, 0, 1, 1);
        spr(0, 10'h3F1, 32'hAE000000, 1, 0);
        spr(0, 10'h3F1, 0, 0, 2);
        spr(1, 10'h3B9, 32'h5, 1, 0);
        EVENT_HIT = 4'h1;
        repeat (3) pulse_edge;
        EVENT_HIT = 0;
        spr(0, 10'h3A9, 32'h8, 0, 0);
        spr(1, 10'h3A9, 32'h9, 0, 1);
        CURRENT_PC = 32'h4A00; PERF_SIGNAL = 1;
        pulse_edge;
        PERF_SIGNAL = 0;
        spr(0, 10'h3AB, 32'h4A00, 0, 0);
        spr(1, 10'h398, 0, 1, 1);
        spr(1, 10'h210, 32'h3, 1, 0);
        spr(1, 10'h211, 32'h8, 1, 0);
        spr(0, 10'h211, 32'h8, 1, 0);
        FETCH_EA = 32'h1000; FETCH_VALID = 1;
        pulse_edge;
        FETCH_VALID = 0;
        chk(FETCH_GUARD_FAULT, 1);
        SEG_IDX = 4'h5; FETCH_SEG_IDX = 4'h5; SEG_WDATA = 32'h80000123; SEG_WE = 1;
        pulse_edge;
        SEG_WE = 0;
        repeat (2) pulse_edge;
        chk(SEG_RDATA, 32'h80000123);
        chk(FETCH_SEG_DATA, 32'h80000123);
        EXC_PC = 32'h2000; EXC_MSR = 32'h8030; EXC_EA = 32'hABC; EXC_CAUSE = 32'h42000000;
        EXC_DATA_FAULT = 1; EXC_TAKE = 1;
        pulse_edge;
        EXC_TAKE = 0; EXC_DATA_FAULT = 0;
        pulse_edge;
        chk(RESUME_PC, 32'h2000);
        spr(0, 10'h013, 32'hABC, 1, 0);
        spr(0, 10'h012, 32'h42000000, 1, 0);
        spr(0, 10'h01B, 32'h8030, 1, 0);
        EXC_MCHK = 1; MCHK_CAUSE = 6'h3F; EXC_TAKE = 1;
        pulse_edge;
        EXC_TAKE = 0; EXC_MCHK = 0;
        spr(0, 10'h01B, 32'h081F8030, 1, 0);
        spr(1, 10'h3FE, 32'h1, 1, 0);
        spr(1, 10'h3FC, 32'h08000003, 1, 0);
        chk(THERM_EXC, 1);
        spr(0, 10'h3FC, 32'hC8000003, 1, 0);
        conclude;
    end
endmodule
